// ==== src/byte_load_defines.vh ====
// constants for the indirect-with-displacement byte load
`ifndef BYTE_LOAD_DEFINES_VH
`define BYTE_LOAD_DEFINES_VH
`define OPC_HI            7'h57
`define OPC_MSB           15
`define OPC_LSB           9
`define SRC_MSB           8
`define SRC_LSB           5
`define FSEL_BIT          4
`define DST_MSB           3
`define DST_LSB           0
`define FIELD_BITS        8
`define STATES_FAST       4'h5
`define STATES_SLOW       4'hb
`endif

// ==== src/byte_field_extract.v ====
// extracts an 8-bit field at a bit offset of 0 to 15 from two memory words
`timescale 1ns/1ns
module byte_field_extract #(
  parameter WORD_W = 16
) (
  input  wire [2*WORD_W-1:0] i_words,
  input  wire [3:0]          i_bit_off,
  output wire [7:0]          o_byte
);
  wire [2*WORD_W-1:0] shifted;
  assign shifted = i_words >> i_bit_off;
  assign o_byte  = shifted[7:0]; // RL2
endmodule

// ==== src/byte_load_indirect_offset.v ====
// execution of the byte move instruction, indirect with displacement to register
// Contract
// RL1: address is pointer plus signed 16-bit displacement
// RL2: fetch exactly 8 bits at that address
// RL3: right-align byte, sign extend to 32
// RL4: compare loaded field to zero, set flags
// RL5: both registers from one file select
// RL6: aligned byte finishes in 5 or 11 states
// RL7: two-word instruction, displacement in second word
`timescale 1ns/1ns
`include "byte_load_defines.vh"
module byte_load_indirect_offset #(
  parameter ADDR_W = 32,
  parameter WORD_W = 16
) (
  input  wire                i_mclk,
  input  wire                i_rst_n,
  input  wire                i_insn_valid,
  input  wire [WORD_W-1:0]   i_insn_word0,
  input  wire [WORD_W-1:0]   i_insn_word1,
  input  wire                i_slow_path,
  output wire                o_insn_ready,
  output reg                 o_illegal,
  output reg  [4:0]          o_rf_rd_idx,
  input  wire [31:0]         i_rf_rd_data,
  output reg                 o_mem_req,
  output reg  [ADDR_W-1:0]   o_mem_addr,
  input  wire                i_mem_ack,
  input  wire [2*WORD_W-1:0] i_mem_data,
  output reg                 o_rf_we,
  output reg  [4:0]          o_rf_wr_idx,
  output reg  [31:0]         o_rf_wr_data,
  output reg                 o_flag_we,
  output reg                 o_flag_n,
  output reg                 o_flag_z,
  output reg                 o_flag_v,
  output reg                 o_done
);
  // sequencer states
  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_FETCH = 3'h2;
  localparam ST_WAIT  = 3'h3;
  localparam ST_WB    = 3'h4;

  reg               rst_m_ff;
  reg               rst_s_ff;
  reg  [2:0]        state_ff;
  reg  [2:0]        nxt_state;
  reg  [3:0]        cnt_ff;
  reg  [3:0]        nxt_cnt;
  reg  [3:0]        target_ff;
  reg  [4:0]        dst_ff;
  reg  [15:0]       disp_ff;
  reg  [7:0]        byte_ff;
  wire              rst_n;
  wire [7:0]        fetched;
  wire              opc_ok;
  wire              take;
  wire [ADDR_W-1:0] eff_addr;

  // pointer and destination share the file select bit
  function [4:0] ptr_index;
    input [WORD_W-1:0] word;
    begin
      ptr_index = {word[`FSEL_BIT], word[`SRC_MSB:`SRC_LSB]}; // RL5
    end
  endfunction

  function [4:0] dst_index;
    input [WORD_W-1:0] word;
    begin
      dst_index = {word[`FSEL_BIT], word[`DST_MSB:`DST_LSB]}; // RL5
    end
  endfunction

  // right-aligned byte with its msb copied upward
  function [31:0] sign_fill;
    input [7:0] field;
    begin
      sign_fill = {{24{field[7]}}, field}; // RL3
    end
  endfunction

  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_m_ff <= 1'b0;
      rst_s_ff <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_s_ff <= rst_m_ff;
    end
  end
  assign rst_n = rst_s_ff;

  assign opc_ok = (i_insn_word0[`OPC_MSB:`OPC_LSB] == `OPC_HI); // RL7
  // instruction accepted at this edge
  assign take = o_insn_ready && i_insn_valid && opc_ok;
  assign o_insn_ready = (state_ff == ST_IDLE);
  // sign-extended displacement added to pointer
  assign eff_addr = i_rf_rd_data[ADDR_W-1:0] +
                    {{(ADDR_W-16){disp_ff[15]}}, disp_ff}; // RL1

  // field starts at the low bits of the bit address
  byte_field_extract #(
    .WORD_W (WORD_W)
  ) u_extract (
    .i_words   (i_mem_data),
    .i_bit_off (o_mem_addr[3:0]),
    .o_byte    (fetched)
  );

  always @* begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 4'h1;
    case (state_ff)
      ST_IDLE: begin
        nxt_cnt = 4'h0;
        if (i_insn_valid && opc_ok) begin
          nxt_state = ST_ADDR;
          nxt_cnt   = 4'h1;
        end
      end
      ST_ADDR: begin
        nxt_state = ST_FETCH;
      end
      ST_FETCH: begin
        if (i_mem_ack) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // a late ack shortens the slow-path wait, the count keeps running through the fetch
        if (cnt_ff >= target_ff - 4'h1) begin
          nxt_state = ST_WB; // RL6
        end
      end
      ST_WB: begin
        nxt_state = ST_IDLE;
        nxt_cnt   = 4'h0;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // state and machine-state counter
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= 4'h0;
      target_ff <= `STATES_FAST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (take) begin
        target_ff <= i_slow_path ? `STATES_SLOW : `STATES_FAST; // RL6
      end
    end
  end

  // instruction capture and pointer read index
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      dst_ff      <= 5'h00;
      disp_ff     <= 16'h0000;
      o_rf_rd_idx <= 5'h00;
      o_illegal   <= 1'b0;
    end else begin
      o_illegal <= o_insn_ready && i_insn_valid && !opc_ok; // RL7
      if (take) begin
        dst_ff      <= dst_index(i_insn_word0); // RL5
        o_rf_rd_idx <= ptr_index(i_insn_word0); // RL5
        disp_ff     <= i_insn_word1[15:0]; // RL7
      end
    end
  end

  // memory request held until acknowledged
  // data is only valid in the cycle of the acknowledge
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_mem_req  <= 1'b0;
      o_mem_addr <= {ADDR_W{1'b0}};
      byte_ff    <= 8'h00;
    end else begin
      if (state_ff == ST_ADDR) begin
        o_mem_addr <= eff_addr; // RL1
        o_mem_req  <= 1'b1;
      end else if (state_ff == ST_FETCH && i_mem_ack) begin
        o_mem_req <= 1'b0;
        byte_ff   <= fetched; // RL2
      end else if (state_ff != ST_FETCH) begin
        o_mem_req <= 1'b0;
      end
    end
  end

  // write-back strobes pulse for one cycle
  always @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_rf_we      <= 1'b0;
      o_rf_wr_idx  <= 5'h00;
      o_rf_wr_data <= 32'h0000_0000;
      o_flag_we    <= 1'b0;
      o_flag_n     <= 1'b0;
      o_flag_z     <= 1'b0;
      o_flag_v     <= 1'b0;
      o_done       <= 1'b0;
    end else begin
      o_rf_we   <= (state_ff == ST_WB);
      o_flag_we <= (state_ff == ST_WB);
      o_done    <= (state_ff == ST_WB);
      if (state_ff == ST_WB) begin
        o_rf_wr_idx  <= dst_ff;
        o_rf_wr_data <= sign_fill(byte_ff); // RL3
        o_flag_n     <= byte_ff[7]; // RL4
        o_flag_z     <= (byte_ff == 8'h00); // RL4
        o_flag_v     <= 1'b0;
      end
    end
  end
endmodule

// ==== verification/load_props_properties.sv ====
// property checker for the byte load block
`timescale 1ns/1ns
module load_props (
  input wire        i_mclk,
  input wire        i_rst_n,
  input wire        i_insn_valid,
  input wire [15:0] i_insn_word0,
  input wire [15:0] i_insn_word1,
  input wire        i_slow_path,
  input wire        o_insn_ready,
  input wire        o_illegal,
  input wire [4:0]  o_rf_rd_idx,
  input wire [31:0] i_rf_rd_data,
  input wire [31:0] o_mem_addr,
  input wire        o_mem_req,
  input wire        o_rf_we,
  input wire [31:0] o_rf_wr_data,
  input wire        o_flag_z,
  input wire        o_done
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  wire        op = i_insn_valid && o_insn_ready && i_insn_word0[15:9] == 7'h57;
  wire [31:0] dx = {{16{i_insn_word1[15]}}, i_insn_word1};
  wire [4:0]  ri = {i_insn_word0[4], i_insn_word0[8:5]};
  sequence s_wait5; !o_done [*5]; endsequence
  sequence s_wait11; s_wait5 ##1 !o_done [*6]; endsequence
  a_addr_sum: assert property (op |-> ##2 o_mem_addr == $past(i_rf_rd_data) + $past(dx, 2))
    else $error("address wrong");
  a_read_sel: assert property (op |=> o_rf_rd_idx == $past(ri))
    else $error("read index wrong");
  a_sign_fill: assert property (o_rf_we |-> o_rf_wr_data[31:8] == {24{o_rf_wr_data[7]}})
    else $error("sign fill wrong");
  a_zero_flag: assert property (o_rf_we |-> o_flag_z == (o_rf_wr_data == 32'h0))
    else $error("zero flag wrong");
  a_fast_count: assert property (op && !i_slow_path |=> s_wait5)
    else $error("fast finish early");
  a_slow_count: assert property (op && i_slow_path |=> s_wait11)
    else $error("slow finish early");
  a_bad_code: assert property (i_insn_valid && o_insn_ready && !i_insn_word0[15] |=> o_illegal)
    else $error("bad opcode accepted");
  sequence s_fetch_start; ##2 o_mem_req; endsequence
  a_req_issue: assert property (op |-> s_fetch_start)
    else $error("fetch not requested");
  a_fast_done: assert property (op && !i_slow_path |-> ##[6:20] o_done)
    else $error("fast finish missing");
  a_slow_done: assert property (op && i_slow_path |-> ##[12:20] o_done)
    else $error("slow finish missing");
endmodule
bind byte_load_indirect_offset load_props u_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_insn_valid(i_insn_valid), .i_insn_word0(i_insn_word0), .i_insn_word1(i_insn_word1),
  .i_slow_path(i_slow_path), .o_insn_ready(o_insn_ready), .o_illegal(o_illegal),
  .o_rf_rd_idx(o_rf_rd_idx), .i_rf_rd_data(i_rf_rd_data), .o_mem_addr(o_mem_addr),
  .o_mem_req(o_mem_req), .o_rf_we(o_rf_we), .o_rf_wr_data(o_rf_wr_data),
  .o_flag_z(o_flag_z), .o_done(o_done));

// ==== verification/mem_partner.sv ====
// memory and pointer register stand-in
`timescale 1ns/1ns
module mem_partner (
  input  wire        i_clk,
  input  wire        i_req,
  input  wire [31:0] i_addr,
  input  wire [4:0]  i_idx,
  output reg         o_ack = 1'h0,
  output wire [31:0] o_data,
  output wire [31:0] o_ptr
);
  reg  [1:0]  wait_ff = 2'h0;
  wire [31:0] word = {4'h0, i_addr[31:4]} * 32'h9e3779b9;
  assign o_ptr = {i_idx, 27'h0012340};
  // inverted outside the answer cycle
  assign o_data = o_ack ? word : ~word;
  always @(posedge i_clk) begin
    o_ack <= i_req && !o_ack && wait_ff == i_addr[5:4];
    wait_ff <= (i_req && !o_ack) ? wait_ff + 2'h1 : 2'h0;
  end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the byte load block
`timescale 1ns/1ns
module testbench;
  logic i_mclk = 1'h0, i_rst_n = 1'h0, i_insn_valid = 1'h0, i_slow_path = 1'h0;
  logic [15:0] i_insn_word0 = 16'h0, i_insn_word1 = 16'h0;
  logic o_insn_ready, o_illegal, o_mem_req, i_mem_ack, o_rf_we, o_flag_we, o_flag_n;
  logic o_flag_z, o_flag_v, o_done;
  logic [4:0] o_rf_rd_idx, o_rf_wr_idx;
  logic [31:0] i_rf_rd_data, o_mem_addr, i_mem_data, o_rf_wr_data, a, d;
  int num_errors = 0, comparisons = 0, seed = 42282, n;
  byte_load_indirect_offset DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_insn_valid(i_insn_valid), .i_insn_word0(i_insn_word0), .i_insn_word1(i_insn_word1),
    .i_slow_path(i_slow_path), .o_insn_ready(o_insn_ready), .o_illegal(o_illegal),
    .o_rf_rd_idx(o_rf_rd_idx), .i_rf_rd_data(i_rf_rd_data), .o_mem_req(o_mem_req),
    .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack), .i_mem_data(i_mem_data),
    .o_rf_we(o_rf_we), .o_rf_wr_idx(o_rf_wr_idx), .o_rf_wr_data(o_rf_wr_data),
    .o_flag_we(o_flag_we), .o_flag_n(o_flag_n), .o_flag_z(o_flag_z),
    .o_flag_v(o_flag_v), .o_done(o_done));
  mem_partner u_mem (.i_clk(i_mclk), .i_req(o_mem_req), .i_addr(o_mem_addr), .i_idx(o_rf_rd_idx),
    .o_ack(i_mem_ack), .o_data(i_mem_data), .o_ptr(i_rf_rd_data));
  initial forever #10 i_mclk = ~i_mclk;
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    comparisons++;
    num_errors += (seen !== exp);
    if (seen !== exp) $display("mismatch %s expected %h seen %h", nm, exp, seen);
  endtask
  task finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task run(input [15:0] w0, input [15:0] w1, input s);
    a = {w0[4], w0[8:5], 27'h0012340} + {{16{w1[15]}}, w1};
    d = ({4'h0, a[31:4]} * 32'h9e3779b9) >> a[3:0];
    @(posedge i_mclk);
    {i_insn_valid, i_insn_word0, i_insn_word1, i_slow_path} <= {1'h1, w0, w1, s};
    @(negedge i_mclk);
    chk("ready", o_insn_ready, 32'h1);
    @(posedge i_mclk);
    i_insn_valid <= 1'h0;
    @(negedge i_mclk);
    chk("busy", o_insn_ready, w0[15:9] != 7'h57);
    for (n = 1; n < 30 && !o_done && !o_illegal; n++) @(negedge i_mclk);
    chk("end", {o_illegal, o_done}, {w0[15:9] != 7'h57, w0[15:9] == 7'h57});
    if (w0[15:9] == 7'h57) begin
      chk("states", n - 1, s ? 11 : 5 + a[5:4]);
      chk("strobes", {o_rf_we, o_flag_we, o_mem_req, o_insn_ready}, 4'hd);
      chk("data", o_rf_wr_data, {{24{d[7]}}, d[7:0]});
      chk("index", o_rf_wr_idx, {w0[4], w0[3:0]});
      chk("flags", {o_flag_n, o_flag_z, o_flag_v}, {d[7], d[7:0] == 8'h0, 1'h0});
    end
    $display("test %h %h done", w0, w1);
  endtask
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    repeat (3) @(posedge i_mclk);
    run(16'hae00, 16'h8000, 1'h0);
    run(16'haf1f, 16'h7fff, 1'h1);
    run(16'h1234, 16'hffff, 1'h0);
    repeat (40) run({7'h57, 9'($random(seed))}, 16'($random(seed)), 1'($random(seed)));
    finish_test;
  end
  initial begin
    #100000 num_errors++;
    finish_test;
  end
endmodule
